// ---- hdl/scpi_top.sv ----
// status/control process image packer with apb configuration
`timescale 1ns/1ns
`include "scpi_regs.svh"

// Contract
// [RQ1] without switching outputs, mode 1 ignores output byte 0 entirely
// [RQ2] without switching outputs, mode 1 byte 1 odd bits drive pin 2 of ports 8..5
// [RQ3] mode 1 output byte 2 bit n requests link mode for port n+1
// [RQ4] mode 1 output byte 3 is reserved and has no function
// [RQ5] link request switches a plain input port to link mode, no process data
// [RQ6] pin 4 output acts only on ports configured as digital output
// [RQ7] mapping mode 2 selects the compatibility layouts
// [RQ8] mode 2 input byte 0 bit n reports pin 4 input of port n+1
// [RQ9] mode 2 input byte 1 bit n reports pin 2 input of port n+1
// [RQ10] input byte 2 bit n shows link established on port n+1
// [RQ11] input byte 3 bit n shows valid process data on port n+1
// [RQ12] mode 2 with switching outputs, output byte 0 bit n drives pin 4 of port n+1
// [RQ13] mode 2 output byte 1 bits 7..4 drive pin 2 of ports 8..5
// [RQ14] mode 2 output byte 2 bit n requests link mode for port n+1
// [RQ15] mode 2 output byte 3 stays reserved
// [RQ16] the module always carries four input and four output bytes
// [RQ17] mode 1 input bytes interleave pin 4 on even and pin 2 on odd bits
// [RQ18] before the first output frame all outputs and flags stay inactive
module scpi_top #(
    parameter bit HAS_SWITCH_OUTPUTS = 1'b1
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`SCPI_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire scpi_pkg::scpi_image_s out_image_in,
    input wire logic out_image_valid_in,
    output scpi_pkg::scpi_image_s in_image_out,
    input wire scpi_pkg::scpi_port_in_s ports_in,
    output scpi_pkg::scpi_port_out_s ports_out,
    output logic irq_out
);

    logic rst_meta_n;
    logic rst_sync_n;
    scpi_pkg::scpi_mode_e mode;
    scpi_pkg::scpi_state_e state;
    logic [7:0] do_cfg;
    logic [7:0] di_cfg;
    logic [`SCPI_IRQ_W-1:0] irq_stat;
    logic [`SCPI_IRQ_W-1:0] irq_mask;
    logic [`SCPI_IRQ_W-1:0] irq_event;
    logic [`SCPI_IRQ_W-1:0] irq_clear;
    scpi_pkg::scpi_image_s out_img;
    scpi_pkg::scpi_image_s next_in_image;
    scpi_pkg::scpi_port_out_s next_ports;
    logic [7:0] link_q;
    logic [7:0] pdv_q;
    logic [31:0] next_prdata;
    logic addr_hit;
    logic apb_acc;
    logic apb_wr;
    logic [7:0] ob0;
    logic [7:0] ob1;
    logic [7:0] ob2;
    logic [3:0] ob1_hi;
    logic primed;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_sync_n);

    // async assert, release through two flops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // apb: one wait state, answer registered
    assign apb_acc = psel_in & penable_in & ~pready_out;
    assign apb_wr = psel_in & penable_in & pready_out & pwrite_in & addr_hit;

    always_comb begin
        addr_hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr_in)
            `SCPI_ADDR_CTRL: begin
                next_prdata[`SCPI_CTRL_MODE_BIT] = mode;
                next_prdata[`SCPI_CTRL_DOCFG_LSB +: 8] = do_cfg;
                next_prdata[`SCPI_CTRL_DICFG_LSB +: 8] = di_cfg;
            end
            `SCPI_ADDR_IN_IMG: begin
                next_prdata = in_image_out;
            end
            `SCPI_ADDR_OUT_IMG: begin
                next_prdata = out_img;
            end
            `SCPI_ADDR_IRQ_STAT: begin
                next_prdata[`SCPI_IRQ_W-1:0] = irq_stat;
            end
            `SCPI_ADDR_IRQ_MASK: begin
                next_prdata[`SCPI_IRQ_W-1:0] = irq_mask;
            end
            `SCPI_ADDR_PORT_STATE: begin
                next_prdata[15:0] = {ports_out.pd_exchange, ports_out.io_link_mode};
                next_prdata[16] = primed;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= apb_acc;
            pslverr_out <= apb_acc & ~addr_hit;
            if (apb_acc && !pwrite_in) begin
                prdata_out <= next_prdata;
            end
        end
    end

    // [RQ7] mode and port configuration
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode <= scpi_pkg::SCPI_MODE1;
            do_cfg <= 8'h00;
            di_cfg <= 8'hFF;
            irq_mask <= `SCPI_IRQ_MASK_RST;
        end else if (apb_wr && paddr_in == `SCPI_ADDR_CTRL) begin
            mode <= scpi_pkg::scpi_mode_e'(pwdata_in[`SCPI_CTRL_MODE_BIT]);
            do_cfg <= pwdata_in[`SCPI_CTRL_DOCFG_LSB +: 8];
            di_cfg <= pwdata_in[`SCPI_CTRL_DICFG_LSB +: 8];
        end else if (apb_wr && paddr_in == `SCPI_ADDR_IRQ_MASK) begin
            irq_mask <= pwdata_in[`SCPI_IRQ_W-1:0];
        end
    end

    // [RQ18] wait for first output frame
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= scpi_pkg::SCPI_WAIT;
        end else begin
            case (state)
                scpi_pkg::SCPI_WAIT: begin
                    if (out_image_valid_in) begin
                        state <= scpi_pkg::SCPI_RUN;
                    end
                end
                scpi_pkg::SCPI_RUN: begin
                    state <= scpi_pkg::SCPI_RUN;
                end
                default: begin
                    state <= scpi_pkg::SCPI_WAIT;
                end
            endcase
        end
    end

    assign primed = (state == scpi_pkg::SCPI_RUN);

    // [RQ16] whole four-byte frame latched at once
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_img <= '0;
        end else if (out_image_valid_in) begin
            out_img <= out_image_in;
        end
    end

    // [RQ4] byte 3 feeds no port output, so reserved bits stay inert
    // [RQ15] mode 2 byte 3 likewise unused
    assign ob0 = out_img.b0;
    assign ob1 = out_img.b1;
    assign ob2 = out_img.b2;
    assign ob1_hi = out_img.b1[7:4];

    // output unpacking; out_img is zero until the first frame
    always_comb begin
        next_ports = '0;
        case (mode)
            scpi_pkg::SCPI_MODE1: begin
                for (int i = 0; i < 4; i++) begin
                    // [RQ1] byte 0 dropped on variant without switching outputs
                    if (HAS_SWITCH_OUTPUTS) begin
                        next_ports.pin4_do[i] = ob0[2*i];
                        next_ports.pin4_do[i+4] = ob1[2*i];
                    end
                    // [RQ2] odd bits of byte 1 to pin 2 of ports 5..8
                    next_ports.pin2_do[i+4] = ob1[2*i+1];
                end
                // [RQ3] request bits one per port
                next_ports.temporary_link_request = ob2;
            end
            scpi_pkg::SCPI_MODE2: begin
                // [RQ12] byte 0 straight to pin 4
                if (HAS_SWITCH_OUTPUTS) begin
                    next_ports.pin4_do = ob0;
                end
                // [RQ13] low nibble has no function
                next_ports.pin2_do[7:4] = ob1_hi;
                // [RQ14] request bits one per port
                next_ports.temporary_link_request = ob2;
            end
            default: begin
                next_ports.temporary_link_request = 8'h00;
            end
        endcase
        // [RQ6] pin 4 only where configured as output
        next_ports.pin4_do = next_ports.pin4_do & do_cfg & ~next_ports.temporary_link_request;
        // [RQ5] requested plain input ports go to link mode, no process data
        next_ports.io_link_mode = next_ports.temporary_link_request & di_cfg;
        next_ports.pd_exchange = primed ? ~next_ports.temporary_link_request : 8'h00;
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ports_out <= '0;
        end else begin
            ports_out <= next_ports;
        end
    end

    // input packing, all zero until primed
    always_comb begin
        next_in_image = '0;
        if (primed) begin
            case (mode)
                scpi_pkg::SCPI_MODE1: begin
                    // [RQ17] interleave pin 4 even, pin 2 odd
                    for (int i = 0; i < 4; i++) begin
                        next_in_image.b0[2*i] = ports_in.pin4_di[i];
                        next_in_image.b0[2*i+1] = ports_in.pin2_di[i];
                        next_in_image.b1[2*i] = ports_in.pin4_di[i+4];
                        next_in_image.b1[2*i+1] = ports_in.pin2_di[i+4];
                    end
                end
                scpi_pkg::SCPI_MODE2: begin
                    // [RQ8] pin 4 inputs by port
                    next_in_image.b0 = ports_in.pin4_di;
                    // [RQ9] pin 2 inputs by port
                    next_in_image.b1 = ports_in.pin2_di;
                end
                default: begin
                    next_in_image.b0 = 8'h00;
                end
            endcase
            // [RQ10] link state flags
            next_in_image.b2 = ports_in.link_established_flags;
            // [RQ11] valid flags; no process data while a link request holds
            next_in_image.b3 = ports_in.process_data_valid_flags & ~ports_out.temporary_link_request;
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_image_out <= '0;
        end else begin
            in_image_out <= next_in_image;
        end
    end

    // interrupt events, set wins over a write-one clear
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            link_q <= 8'h00;
            pdv_q <= 8'h00;
        end else begin
            link_q <= ports_in.link_established_flags;
            pdv_q <= ports_in.process_data_valid_flags;
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[`SCPI_IRQ_FRAME] = out_image_valid_in;
        irq_event[`SCPI_IRQ_LINK] = |(link_q ^ ports_in.link_established_flags);
        irq_event[`SCPI_IRQ_PDV] = |(pdv_q ^ ports_in.process_data_valid_flags);
        irq_clear = '0;
        if (apb_wr && paddr_in == `SCPI_ADDR_IRQ_STAT) begin
            irq_clear = pwdata_in[`SCPI_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_stat <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clear) | irq_event;
            irq_out <= |(irq_stat & irq_mask);
        end
    end

    property p_no_sw_byte0;
        (!HAS_SWITCH_OUTPUTS && mode == scpi_pkg::SCPI_MODE1) |=> ports_out.pin4_do == 8'h00;
    endproperty
    a_no_sw_byte0: assert property (p_no_sw_byte0) else $error("pin 4 driven from ignored byte 0"); // [RQ1]

    property p_mode1_pin2;
        (mode == scpi_pkg::SCPI_MODE1) |=> ports_out.pin2_do ==
            {$past(ob1[7]), $past(ob1[5]), $past(ob1[3]), $past(ob1[1]), 4'h0};
    endproperty
    a_mode1_pin2: assert property (p_mode1_pin2) else $error("mode 1 pin 2 outputs wrong"); // [RQ2]

    property p_mode1_req;
        (mode == scpi_pkg::SCPI_MODE1) |=> ports_out.temporary_link_request == $past(ob2);
    endproperty
    a_mode1_req: assert property (p_mode1_req) else $error("mode 1 link request wrong"); // [RQ3]

    property p_req_no_pd;
        (ports_out.pd_exchange & ports_out.temporary_link_request) == 8'h00;
    endproperty
    a_req_no_pd: assert property (p_req_no_pd) else $error("process data during link request"); // [RQ5]

    property p_do_cfg;
        1'b1 |=> (ports_out.pin4_do & ~$past(do_cfg)) == 8'h00;
    endproperty
    a_do_cfg: assert property (p_do_cfg) else $error("pin 4 output on unconfigured port"); // [RQ6]

    property p_mode2_in;
        (primed && mode == scpi_pkg::SCPI_MODE2) |=>
            in_image_out.b0 == $past(ports_in.pin4_di) && in_image_out.b1 == $past(ports_in.pin2_di);
    endproperty
    a_mode2_in: assert property (p_mode2_in) else $error("mode 2 input bytes wrong"); // [RQ8]

    property p_link_flags;
        primed |=> in_image_out.b2 == $past(ports_in.link_established_flags);
    endproperty
    a_link_flags: assert property (p_link_flags) else $error("link flag byte wrong"); // [RQ10]

    property p_mode2_pin4;
        (HAS_SWITCH_OUTPUTS && mode == scpi_pkg::SCPI_MODE2) |=>
            ports_out.pin4_do == ($past(ob0) & $past(do_cfg) & ~$past(ob2));
    endproperty
    a_mode2_pin4: assert property (p_mode2_pin4) else $error("mode 2 pin 4 outputs wrong"); // [RQ12]

    property p_mode2_pin2;
        (mode == scpi_pkg::SCPI_MODE2) |=> ports_out.pin2_do == {$past(ob1_hi), 4'h0};
    endproperty
    a_mode2_pin2: assert property (p_mode2_pin2) else $error("mode 2 pin 2 outputs wrong"); // [RQ13]

    property p_mode1_in;
        (primed && mode == scpi_pkg::SCPI_MODE1) |=>
            in_image_out.b0[1:0] == {$past(ports_in.pin2_di[0]), $past(ports_in.pin4_di[0])} &&
            in_image_out.b1[7:6] == {$past(ports_in.pin2_di[7]), $past(ports_in.pin4_di[7])};
    endproperty
    a_mode1_in: assert property (p_mode1_in) else $error("mode 1 input interleave wrong"); // [RQ17]

    property p_quiet_before_frame;
        (!primed && !out_image_valid_in) |=> in_image_out == '0 && ports_out == '0;
    endproperty
    a_quiet_before_frame: assert property (p_quiet_before_frame) else $error("activity before first frame"); // [RQ18]

    property p_mode2_req;
        (mode == scpi_pkg::SCPI_MODE2) |=> ports_out.temporary_link_request == $past(ob2);
    endproperty
    a_mode2_req: assert property (p_mode2_req) else $error("mode 2 link request wrong"); // [RQ14]

    property p_pdv_flags;
        primed |=> in_image_out.b3 ==
            ($past(ports_in.process_data_valid_flags) & ~$past(ports_out.temporary_link_request));
    endproperty
    a_pdv_flags: assert property (p_pdv_flags) else $error("process data valid byte wrong"); // [RQ11]

endmodule

// ---- common/scpi_regs.svh ----
// register offsets, field positions and reset values of the process image block
`ifndef SCPI_REGS_SVH
`define SCPI_REGS_SVH

`define SCPI_ADDR_W 12
`define SCPI_ADDR_CTRL 12'h000
`define SCPI_ADDR_IN_IMG 12'h004
`define SCPI_ADDR_OUT_IMG 12'h008
`define SCPI_ADDR_IRQ_STAT 12'h00C
`define SCPI_ADDR_IRQ_MASK 12'h010
`define SCPI_ADDR_PORT_STATE 12'h014

`define SCPI_CTRL_MODE_BIT 0
`define SCPI_CTRL_DOCFG_LSB 8
`define SCPI_CTRL_DICFG_LSB 16
`define SCPI_CTRL_RST 32'h00FF_0000

`define SCPI_IRQ_W 3
`define SCPI_IRQ_FRAME 0
`define SCPI_IRQ_LINK 1
`define SCPI_IRQ_PDV 2
`define SCPI_IRQ_MASK_RST 3'h0

`endif

// ---- common/scpi_pkg.sv ----
// types shared by the process image block
package scpi_pkg;

    typedef enum logic [0:0] {
        SCPI_MODE1 = 1'b0,
        SCPI_MODE2 = 1'b1
    } scpi_mode_e;

    typedef enum logic [0:0] {
        SCPI_WAIT = 1'b0,
        SCPI_RUN = 1'b1
    } scpi_state_e;

    typedef struct packed {
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } scpi_image_s;

    typedef struct packed {
        logic [7:0] pin4_di;
        logic [7:0] pin2_di;
        logic [7:0] link_established_flags;
        logic [7:0] process_data_valid_flags;
    } scpi_port_in_s;

    typedef struct packed {
        logic [7:0] pin4_do;
        logic [7:0] pin2_do;
        logic [7:0] temporary_link_request;
        logic [7:0] io_link_mode;
        logic [7:0] pd_exchange;
    } scpi_port_out_s;

endpackage

// ---- tb/scpi_ctrl_model.sv ----
// network controller model that sends cyclic output images
`timescale 1ns/1ns
module scpi_ctrl_model (
    input wire logic clk_in,
    output scpi_pkg::scpi_image_s out_image_out,
    output logic out_image_valid_out
);
    initial begin
        out_image_out = '0;
        out_image_valid_out = 1'b0;
    end
    task automatic send(input scpi_pkg::scpi_image_s im);
        @(posedge clk_in);
        out_image_out <= im;
        out_image_valid_out <= 1'b1;
        @(posedge clk_in);
        out_image_valid_out <= 1'b0;
        // released lines show no stale copy
        out_image_out <= ~im;
    endtask
endmodule

// ---- tb/scpi_top_bench.sv ----
// self-checking bench for the process image block
`timescale 1ns/1ns
`include "scpi_regs.svh"
module scpi_top_bench;
    logic clk_in, rstn_in, psel, penable, pwrite, pready_out, pslverr_out, irq_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_out, rd;
    logic er;
    scpi_pkg::scpi_image_s oimg, iimg;
    logic ovld;
    scpi_pkg::scpi_port_in_s pin;
    scpi_pkg::scpi_port_out_s pout, pout_b;
    int fails, samples_checked;

    scpi_ctrl_model ctrl (.clk_in(clk_in), .out_image_out(oimg), .out_image_valid_out(ovld));
    scpi_top #(.HAS_SWITCH_OUTPUTS(1'b1)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .out_image_in(oimg),
        .out_image_valid_in(ovld), .in_image_out(iimg), .ports_in(pin), .ports_out(pout), .irq_out(irq_out));
    scpi_top #(.HAS_SWITCH_OUTPUTS(1'b0)) DUT_NOSW (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(), .pready_out(), .pslverr_out(), .out_image_in(oimg),
        .out_image_valid_in(ovld), .in_image_out(), .ports_in(pin), .ports_out(pout_b), .irq_out());

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        // only the watchdog ends a stuck wait
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic scpi_pkg::scpi_port_out_s exp_out(input logic m2, input logic has,
        input scpi_pkg::scpi_image_s im, input logic [7:0] doc, input logic [7:0] dic);
        scpi_pkg::scpi_port_out_s e;
        int i;
        e = '0;
        for (i = 0; i < 4; i++) begin
            e.pin4_do[i] = im.b0[2*i];
            e.pin4_do[i+4] = im.b1[2*i];
            e.pin2_do[i+4] = im.b1[2*i+1];
        end
        if (m2) begin
            e.pin4_do = im.b0;
            e.pin2_do = {im.b1[7:4], 4'h0};
        end
        e.temporary_link_request = im.b2;
        e.pin4_do = has ? (e.pin4_do & doc & ~im.b2) : 8'h00;
        e.io_link_mode = im.b2 & dic;
        e.pd_exchange = ~im.b2;
        return e;
    endfunction

    function automatic scpi_pkg::scpi_image_s exp_in(input logic m2, input scpi_pkg::scpi_port_in_s p,
        input logic [7:0] rq);
        scpi_pkg::scpi_image_s e;
        int i;
        for (i = 0; i < 4; i++) begin
            e.b0[2*i] = p.pin4_di[i];
            e.b0[2*i+1] = p.pin2_di[i];
            e.b1[2*i] = p.pin4_di[i+4];
            e.b1[2*i+1] = p.pin2_di[i+4];
        end
        if (m2) begin
            e.b0 = p.pin4_di;
            e.b1 = p.pin2_di;
        end
        e.b2 = p.link_established_flags;
        e.b3 = p.process_data_valid_flags & ~rq;
        return e;
    endfunction

    task automatic cfg(input logic m2, input logic [7:0] doc, input logic [7:0] dic);
        apb(1'b1, `SCPI_ADDR_CTRL, {8'h00, dic, doc, 7'h00, m2});
    endtask

    task automatic t_frame(input logic [31:0] im, input logic [31:0] pi, input logic m2,
        input logic [7:0] doc, input logic [7:0] dic);
        @(posedge clk_in);
        pin <= pi;
        ctrl.send(im);
        repeat (3) @(posedge clk_in);
        check("ports_out", exp_out(m2, 1'b1, im, doc, dic), pout);
        check("ports_out_nosw", exp_out(m2, 1'b0, im, doc, dic), pout_b);
        check("in_image", exp_in(m2, pi, im[23:16]), iimg);
    endtask

    task automatic t_reset();
        check("ports_out_idle", 40'h00_0000_0000, pout);
        check("in_image_idle", 40'h00_0000_0000, {8'h00, iimg});
        apb(1'b0, `SCPI_ADDR_CTRL, 32'h0000_0000);
        check("ctrl_reset", {8'h00, `SCPI_CTRL_RST}, {8'h00, rd});
        apb(1'b0, `SCPI_ADDR_IRQ_MASK, 32'h0000_0000);
        check("mask_reset", 40'h00_0000_0000, {8'h00, rd});
        // unmapped place must be refused
        apb(1'b0, 12'h018, 32'h0000_0000);
        check("unmapped_err", 40'h00_0000_0001, {39'h0, er});
        check("unmapped_data", 40'h00_0000_0000, {8'h00, rd});
    endtask

    task automatic t_mode1();
        cfg(1'b0, 8'hFF, 8'hFF);
        t_frame(32'hFF8B_0015, 32'hA53C_F00F, 1'b0, 8'hFF, 8'hFF);
        t_frame(32'h0000_FFFF, 32'h5AC3_0FF0, 1'b0, 8'hFF, 8'hFF);
    endtask

    task automatic t_mode2();
        cfg(1'b1, 8'h5A, 8'hFF);
        t_frame(32'hFF0F_F0A5, 32'hA53C_F00F, 1'b1, 8'h5A, 8'hFF);
        t_frame(32'h00F0_0FFF, 32'h5AC3_0FF0, 1'b1, 8'h5A, 8'hFF);
    endtask

    task automatic t_request();
        cfg(1'b0, 8'hF0, 8'h0F);
        t_frame(32'h003C_FFFF, 32'hFF00_FFFF, 1'b0, 8'hF0, 8'h0F);
        // request moves to ports 1 and 8, process data resume on ports 3..6
        t_frame(32'h0081_FFFF, 32'hFF00_FFFF, 1'b0, 8'hF0, 8'h0F);
        apb(1'b0, `SCPI_ADDR_PORT_STATE, 32'h0000_0000);
        check("port_state", 40'h00_0001_7E01, {8'h00, rd});
        apb(1'b0, `SCPI_ADDR_OUT_IMG, 32'h0000_0000);
        check("out_img_read", 40'h00_0081_FFFF, {8'h00, rd});
        apb(1'b0, `SCPI_ADDR_IN_IMG, 32'h0000_0000);
        check("in_img_read", 40'h00_7EFF_5555, {8'h00, rd});
    endtask

    task automatic t_irq();
        apb(1'b1, `SCPI_ADDR_IRQ_STAT, 32'h0000_0007);
        apb(1'b1, `SCPI_ADDR_IRQ_MASK, 32'h0000_0001);
        t_frame(32'h0000_0000, 32'h0000_0000, 1'b0, 8'hF0, 8'h0F);
        check("irq_raised", 40'h1, {39'h0, irq_out});
        apb(1'b0, `SCPI_ADDR_IRQ_STAT, 32'h0000_0000);
        check("stat_frame", 40'h1, {39'h0, rd[`SCPI_IRQ_FRAME]});
        apb(1'b1, `SCPI_ADDR_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        check("irq_cleared", 40'h0, {39'h0, irq_out});
        apb(1'b1, `SCPI_ADDR_IRQ_MASK, 32'h0000_0000);
        t_frame(32'h0000_0000, 32'h0000_0000, 1'b0, 8'hF0, 8'h0F);
        check("irq_masked", 40'h0, {39'h0, irq_out});
        apb(1'b0, `SCPI_ADDR_IRQ_STAT, 32'h0000_0000);
        check("stat_masked", 40'h1, {39'h0, rd[`SCPI_IRQ_FRAME]});
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        rstn_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pin = 32'h0000_0000;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset();
        t_mode1();
        t_mode2();
        t_request();
        t_irq();
        summarize();
    end

    // whole run is roughly 120 cycles
    initial begin
        #200000;
        fails++;
        summarize();
    end
endmodule
